// file: hdl/acc_dev.sv
// Converter end: start detection, conversion timing, busy/interrupt and read port
`timescale 1ns/10ps
module acc_dev
  import acc_pkg::*;
(
  input wire logic clk,                    // System clock, also converter clock
  input wire logic rstn,                   // Async reset, low
  input wire logic ce,                     // Clock enable
  acc_if.dev bus,                          // Host-facing pins
  input wire logic [DATA_W-1:0] sample_in, // Digitised value of held input
  output logic holding                     // Track/hold in hold, high
);
  acc_dev_state_t state_r, state_nxt;      // Conversion state
  logic st_d_r, cs_d_r, rd_d_r;            // Previous pin levels for edges
  logic [2:0] cnt_r;                       // Bit counter
  logic [DATA_W-1:0] sar_r;                // Approximation register
  logic [DATA_W-1:0] latch_r;              // Output latch
  logic busy_n_r, int_n_r, hold_r, oe_n_r; // Registered outputs
  logic [DATA_W-1:0] held_r;               // Held sample

  // Edge decode on synchronous pins
  wire read_mode = bus.start_convert_n && st_d_r;
  wire st_fall = st_d_r && !bus.start_convert_n;
  wire rd_active = !bus.cs_n && !bus.rd_n;
  wire rd_fall = rd_active && (rd_d_r || cs_d_r);
  wire rd_rise = !int_n_r && ((bus.cs_n && !cs_d_r && !rd_d_r) ||
    (bus.rd_n && !rd_d_r && !cs_d_r));
  // Two start sources, mode chosen by start pin level
  wire start = (state_r == ACC_IDLE) &&
    (st_fall || (read_mode && rd_fall));
  wire last_bit = (cnt_r == 3'(CONV_CYCLES - 1));
  // Current bit of successive approximation, MSB first
  wire [DATA_W-1:0] bit_mask = 8'h80 >> cnt_r;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACC_IDLE: begin
        if (start) state_nxt = ACC_CONV;
      end
      ACC_CONV: begin
        if (last_bit) state_nxt = ACC_DONE;
      end
      ACC_DONE: begin
        state_nxt = ACC_IDLE;
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  // Pin history for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_d_r <= 1'b1;
      cs_d_r <= 1'b1;
      rd_d_r <= 1'b1;
    end else if (ce) begin
      st_d_r <= bus.start_convert_n;
      cs_d_r <= bus.cs_n;
      rd_d_r <= bus.rd_n;
    end
  end

  // State, counter and approximation register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ACC_IDLE;
      cnt_r <= CNT_RST;
      sar_r <= RESULT_RST;
      held_r <= RESULT_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      if (start) begin
        held_r <= sample_in;
        cnt_r <= CNT_RST;
        sar_r <= RESULT_RST;
      end else if (state_r == ACC_CONV) begin
        // Trial bit kept when held value reaches it
        if ((sar_r | bit_mask) <= held_r) sar_r <= sar_r | bit_mask;
        cnt_r <= cnt_r + 3'h1;
      end else if (state_r == ACC_DONE) begin
        sar_r <= RESULT_RST;
      end
    end
  end

  // Output latch: old value stays on the bus until the conversion ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= RESULT_RST;
    end else if (ce && state_r == ACC_DONE) begin
      latch_r <= sar_r;
    end
  end

  // Busy, interrupt, track/hold and bus enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_n_r <= 1'b1;
      int_n_r <= 1'b1;
      hold_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (ce) begin
      if (start) begin
        busy_n_r <= 1'b0;
        hold_r <= 1'b1;
      end else if (state_r == ACC_DONE) begin
        busy_n_r <= 1'b1;
        hold_r <= 1'b0;
      end
      // Finish wins over a clear landing in the same cycle
      if (state_r == ACC_DONE) int_n_r <= 1'b0;
      else if (rd_rise) int_n_r <= 1'b1;
      oe_n_r <= !rd_active;
    end
  end

  assign bus.busy_n = busy_n_r;
  assign bus.int_n = int_n_r;
  assign bus.data_out = latch_r;
  assign bus.data_oe_n = oe_n_r;
  assign holding = hold_r;
endmodule : acc_dev

// file: hdl/acc_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module acc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,               // System clock
  input wire logic rstn,              // Async reset, low
  input wire logic ce,                // Clock enable
  input wire logic in_valid,          // Write side valid
  output logic in_ready,              // Write side ready (not full)
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid,             // Read side valid (not empty)
  input wire logic out_ready,         // Read side ready
  output logic [WIDTH-1:0] out_data   // Read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];    // Storage
  logic [AW-1:0] wp_r;                // Write index
  logic [AW-1:0] rp_r;                // Read index
  logic [AW:0] cnt_r;                 // Fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  // Pointers and level; wrap relies on power-of-two depth
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      if (push && !pop) cnt_r <= cnt_r + (AW+1)'(1);
      else if (pop && !push) cnt_r <= cnt_r - (AW+1)'(1);
    end
  end

  // Storage has no reset; only written entries are read
  always_ff @(posedge clk) begin
    if (ce && push) mem_r[wp_r] <= in_data;
  end
endmodule : acc_fifo

// file: hdl/acc_host.sv
// Host end: issues conversions in either mode, reads results into a FIFO
`timescale 1ns/10ps
module acc_host
  import acc_pkg::*;
(
  input wire logic clk,                  // System clock
  input wire logic rstn,                 // Async reset, low
  input wire logic ce,                   // Clock enable
  acc_if.host bus,                       // Converter pins
  input wire logic mode_read,            // High selects read-initiated mode
  input wire logic req,                  // Request one conversion, pulse or level
  output logic req_busy,                 // Host cannot take a request
  output logic res_valid,                // Result available
  input wire logic res_ready,            // Consumer takes result
  output logic [DATA_W-1:0] res_data     // Result
);
  acc_host_state_t state_r, state_nxt;   // Request state
  logic st_n_r, cs_n_r, rd_n_r;          // Registered pin drives
  logic [4:0] tmr_r;                     // Start pulse width timer
  logic push_r;                          // FIFO write strobe
  logic [DATA_W-1:0] cap_r;              // Captured data
  logic f_ready, f_valid;                // FIFO handshakes
  logic [DATA_W-1:0] f_data;             // FIFO output
  logic rv_r;                            // Registered result valid
  logic [DATA_W-1:0] rd_r;               // Registered result data

  // Requests stall while FIFO is full, so back-pressure reaches the source
  wire go = req && f_ready && (state_r == ACC_H_IDLE);
  wire tmr_done = (tmr_r == 5'(ST_PULSE_CYC - 1));
  wire take = rv_r && res_ready;
  // Last cycle of the read, when the converter's registered bus enable is already on
  wire read_end = (state_r == ACC_H_READ) && (tmr_r == 5'h01);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACC_H_IDLE: begin
        if (go) state_nxt = mode_read ? ACC_H_WAIT : ACC_H_START;
      end
      ACC_H_START: begin
        if (tmr_done) state_nxt = ACC_H_WAIT;
      end
      ACC_H_WAIT: begin
        // Read mode waits in the read cycle; pulse mode waits for interrupt
        if (mode_read ? (bus.busy_n && tmr_r == 5'h1f) : !bus.int_n)
          state_nxt = ACC_H_READ;
      end
      ACC_H_READ: begin
        // Strobes stay low two cycles so the data is driven when captured
        if (tmr_r == 5'h01) state_nxt = ACC_H_IDLE;
      end
      default: begin
        state_nxt = ACC_H_IDLE;
      end
    endcase
  end

  // Pin drives and timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ACC_H_IDLE;
      st_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      tmr_r <= 5'h00;
    end else if (ce) begin
      state_r <= state_nxt;
      // Timer saturates so a late busy release is still seen
      if (state_nxt != state_r) tmr_r <= 5'h00;
      else if (tmr_r != 5'h1f) tmr_r <= tmr_r + 5'h01;
      // Read mode keeps start high; pulse mode holds it low until the read is over,
      // so the read never looks like a read-initiated start
      st_n_r <= mode_read || (state_nxt == ACC_H_IDLE);
      cs_n_r <= !((state_nxt == ACC_H_WAIT && mode_read) ||
        state_nxt == ACC_H_READ);
      rd_n_r <= !((state_nxt == ACC_H_WAIT && mode_read) ||
        state_nxt == ACC_H_READ);
    end
  end

  // Capture at end of read cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_r <= 1'b0;
      cap_r <= RESULT_RST;
    end else if (ce) begin
      push_r <= read_end;
      if (read_end) cap_r <= bus.data;
    end
  end

  acc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) i_acc_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(push_r),
    .in_ready(f_ready),
    .in_data(cap_r),
    .out_valid(f_valid),
    .out_ready(!rv_r || take),
    .out_data(f_data)
  );

  // Output register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rv_r <= 1'b0;
      rd_r <= RESULT_RST;
      req_busy <= 1'b0;
    end else if (ce) begin
      if (!rv_r || take) begin
        rv_r <= f_valid;
        rd_r <= f_data;
      end
      req_busy <= !(state_nxt == ACC_H_IDLE) || !f_ready;
    end
  end

  assign bus.start_convert_n = st_n_r;
  assign bus.cs_n = cs_n_r;
  assign bus.rd_n = rd_n_r;
  assign res_valid = rv_r;
  assign res_data = rd_r;
endmodule : acc_host

// file: hdl/acc_if.sv
// Interface joining the converter end and the host end
`timescale 1ns/10ps
interface acc_if;
  import acc_pkg::*;
  logic start_convert_n;          // Start convert, low pulse in start-pulse mode
  logic cs_n;                     // Chip select
  logic rd_n;                     // Read strobe
  logic busy_n;                   // Conversion in progress, low
  logic int_n;                    // Result available, low
  logic [DATA_W-1:0] data_out;    // Data driven by converter
  logic data_oe_n;                // Converter drives data when low
  wire [DATA_W-1:0] data = data_oe_n ? {DATA_W{1'b1}} : data_out; // Resolved bus

  modport dev (input start_convert_n, input cs_n, input rd_n, output busy_n,
    output int_n, output data_out, output data_oe_n);
  modport host (output start_convert_n, output cs_n, output rd_n, input busy_n,
    input int_n, input data);
endinterface : acc_if

// file: hdl/acc_pkg.sv
// Package with constants and types shared by both ends of the converter read port
// Functional notes
// - Two modes: start pulse, read initiated
// - Start held high selects read-initiated mode
// - Start falling edge begins conversion, holds input
// - Busy low during conversion; tracking resumes after
// - Interrupt cleared by select or strobe rising
// - Interrupt goes low when conversion finishes
// - Host keeps start low when strobing read
// - Host never reads during start-pulse conversion
// - No second start pulse mid-conversion
// - Host must tolerate long wait states
// - Read-initiated: busy low stalls host cycle
// - Sample taken on read strobe falling edge
// - After busy high, new result on bus
// - Old result driven while conversion runs
// - Result is an eight-bit code
// - Eight converter clocks; result latched, register cleared
// - Start pulse covers mux and acquisition time
// - Start may derive from other decoded strobe
package acc_pkg;
  localparam int DATA_W = 8;                      // Result width
  localparam int CONV_CYCLES = 8;                 // Converter clocks per conversion
  localparam int CLK_PERIOD_NS = 100;             // System clock period
  localparam int MIN_WAIT_NS = 2000;              // Least host wait in read-initiated mode
  localparam int MIN_WAIT_CYC = (MIN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST_PULSE_NS = 200;               // Start pulse width for mux scanning
  localparam int ST_PULSE_CYC = (ST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;                  // Host-side result FIFO depth
  localparam logic [7:0] RESULT_RST = 8'h00;      // Output latch reset value
  localparam logic [2:0] CNT_RST = 3'h0;          // Bit counter reset value

  // Device conversion states
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_CONV = 3'b010,
    ACC_DONE = 3'b100
  } acc_dev_state_t;

  // Host request states
  typedef enum logic [3:0] {
    ACC_H_IDLE = 4'b0001,
    ACC_H_START = 4'b0010,
    ACC_H_WAIT = 4'b0100,
    ACC_H_READ = 4'b1000
  } acc_host_state_t;
endpackage : acc_pkg

// file: tb/acc_monitor.sv
// Checker watching the pins between the converter end and the host end
`timescale 1ns/10ps
module acc_monitor
  import acc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, low
  input wire logic start_convert_n, // Start, low
  input wire logic cs_n, // Chip select, low
  input wire logic rd_n, // Read strobe, low
  input wire logic busy_n, // Busy, low
  input wire logic int_n, // Result ready, low
  input wire logic [DATA_W-1:0] data_out, // Converter data
  input wire logic data_oe_n, // Data enable, low
  input wire logic holding // Track/hold holding
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Only an idle converter takes a start
  sequence s_pulse;
    $fell(start_convert_n) && busy_n;
  endsequence
  // Read start needs the start line high for two cycles first
  sequence s_read;
    start_convert_n && $past(start_convert_n) && $fell(cs_n || rd_n) && busy_n;
  endsequence
  // Eight bit steps, one done cycle, then busy, interrupt and tracking flip together
  sequence s_conv;
    ##1 (!busy_n && holding)[*8] ##1 !busy_n ##1 (busy_n && !int_n && !holding);
  endsequence

  pulse_start_a: assert property (s_pulse |-> s_conv)
    else $error("pulse started conversion has wrong timing");
  read_start_a: assert property (s_read |-> s_conv)
    else $error("read started conversion has wrong timing");
  hold_busy_a: assert property (busy_n != holding)
    else $error("hold state differs from busy");
  busy_cause_a: assert property ($fell(busy_n) |->
    !$past(start_convert_n) || (!$past(cs_n) && !$past(rd_n)))
    else $error("busy fell without a start");
  int_keep_a: assert property (!int_n && cs_n && rd_n && $past(cs_n) && $past(rd_n)
    |=> !int_n)
    else $error("interrupt cleared without a read");
  int_clear_a: assert property (!int_n && busy_n && $rose(cs_n || rd_n) |=> int_n)
    else $error("interrupt not cleared by read end");
  old_data_a: assert property (!busy_n |-> $stable(data_out))
    else $error("data changed during conversion");
  oe_on_a: assert property ($fell(cs_n || rd_n) |=> !data_oe_n)
    else $error("data not driven on read");
  rest_a: assert property ($rose(rstn) |-> busy_n && int_n && !holding && data_oe_n)
    else $error("pins not at rest after reset");
endmodule : acc_monitor

// file: tb/adc_conversion_host_control_tb.sv
// Testbench joining both ends and driving the host's user side
`timescale 1ns/10ps
module adc_conversion_host_control_tb
  import acc_pkg::*;
;
  logic clk, rstn, mode_read, req, res_ready, req_busy, res_valid, holding; // Stimulus, flags
  logic [DATA_W-1:0] sample_in, res_data; // Held input and result
  int n_errors, comparisons; // Counters
  int i;

  acc_if bus_if ();
  // Clock enable tied high: the stall path is not exercised here
  acc_dev i_acc_dev (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus_if.dev),
    .sample_in(sample_in), .holding(holding));
  acc_host i_acc_host (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus_if.host),
    .mode_read(mode_read), .req(req), .req_busy(req_busy), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
  acc_monitor i_acc_monitor (.clk(clk), .rstn(rstn),
    .start_convert_n(bus_if.start_convert_n), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
    .busy_n(bus_if.busy_n), .int_n(bus_if.int_n), .data_out(bus_if.data_out),
    .data_oe_n(bus_if.data_oe_n), .holding(holding));

  // Clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Hold the request until the host shows it was taken
  task convert(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    sample_in <= v;
    req <= 1'b1;
    do begin @(posedge clk); #1; n++; end while (req_busy !== 1'b1 && n < 50);
    @(posedge clk);
    req <= 1'b0;
  endtask : convert

  // Bounded wait for the host to become free again
  task idle_wait;
    int n;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (req_busy !== 1'b0 && n < 200);
  endtask : idle_wait

  // Valid/ready pop of one result
  task take(input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    res_ready <= 1'b1;
    do begin @(posedge clk); n++; end while (res_valid !== 1'b1 && n < 200);
    check(res_data, exp);
    res_ready <= 1'b0;
  endtask : take

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(100 * 20000);
    n_errors++;
    conclude();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    mode_read = 1'b0;
    req = 1'b0;
    res_ready = 1'b0;
    sample_in = 8'h00;
    repeat (12) @(posedge clk);
    check({4'h0, bus_if.busy_n, bus_if.int_n, holding, res_valid}, 8'h0c);
    rstn <= 1'b1;
    // Start pulse mode, boundary codes and one mid code
    for (i = 0; i < 3; i++) begin
      convert(i == 0 ? 8'h00 : (i == 1 ? 8'hff : 8'ha5));
      idle_wait();
      take(i == 0 ? 8'h00 : (i == 1 ? 8'hff : 8'ha5));
      check({7'h0, bus_if.int_n}, 8'h01);
    end
    // Read-initiated mode: input moves after the sample is held
    @(posedge clk);
    mode_read <= 1'b1;
    repeat (4) @(posedge clk);
    convert(8'h3c);
    i = 0;
    while (bus_if.busy_n !== 1'b0 && i < 20) begin @(posedge clk); #1; i++; end
    sample_in <= 8'hc3;
    @(posedge clk);
    #1;
    check(bus_if.data, 8'ha5);
    idle_wait();
    take(8'h3c);
    // Fill the FIFO and the output stage with no consumer, then drain them
    @(posedge clk);
    mode_read <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < FIFO_DEPTH + 1; i++) begin
      convert(8'h10 + i[7:0]);
      idle_wait();
    end
    // The last push lands after the host reports idle
    repeat (3) @(posedge clk);
    #1;
    check({7'h0, req_busy}, 8'h01);
    for (i = 0; i < FIFO_DEPTH + 1; i++) take(8'h10 + i[7:0]);
    @(posedge clk);
    #1;
    check({7'h0, res_valid}, 8'h00);
    conclude();
  end
endmodule : adc_conversion_host_control_tb
